// File: prot_agg_pkg.sv
// Constants for the protection trip aggregation and blocking block.
// Assumes a single system clock and an AXI4-Lite master on 32-bit data.
package prot_agg_pkg;

  localparam int NUM_ELEM = 4;
  localparam int NUM_PHASE = 4;
  localparam int NUM_BRK = 2;
  localparam int DLY_W = 16;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ELEM_EN_OFS = 8'h04;
  localparam logic [7:0] SUPERV_OFS = 8'h08;
  localparam logic [7:0] STAGE_BLK_OFS = 8'h0c;
  localparam logic [7:0] PHASE_CAP_OFS = 8'h10;
  localparam logic [7:0] BRK_MAP_OFS = 8'h14;
  localparam logic [7:0] DELAY0_OFS = 8'h18;
  localparam logic [7:0] DELAY1_OFS = 8'h1c;
  localparam logic [7:0] DELAY2_OFS = 8'h20;
  localparam logic [7:0] DELAY3_OFS = 8'h24;
  localparam logic [7:0] STATUS_OFS = 8'h28;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h2c;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h30;

  // Control register fields.
  localparam int CTRL_PROT_EN = 0;
  localparam int CTRL_EXT_BLK_PERMIT = 1;
  localparam int CTRL_TRIP_PERM_BLK = 2;
  localparam int CTRL_EXT_TRIP_PERMIT = 3;

  // Interrupt status fields.
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_TRIP_CMD = 2;
  localparam int IRQ_BLOCKED = 3;

  // Values after reset.
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [3:0] ELEM_EN_RST = 4'hf;
  localparam logic [3:0] SUPERV_RST = 4'h0;
  localparam logic [7:0] STAGE_BLK_RST = 8'h00;
  localparam logic [3:0] PHASE_CAP_RST = 4'hf;
  localparam logic [7:0] BRK_MAP_RST = 8'hff;
  localparam logic [15:0] DELAY_RST = 16'h0000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : prot_agg_pkg

// File: prot_trip_agg.sv
// Protection aggregation: element alarm and trip forming, general and
// per-phase ORs, gated trip commands and breaker assignment.
// Assumes fault inputs come from logic on clk_sys_i; blocking inputs are
// asynchronous pins; registers are reached over AXI4-Lite.
`timescale 1ns/1ps

// Behaviour
// - Protection disabled suppresses all alarms, trips, commands.
// - Permitted external block inputs block all protection.
// - Global permanent block suppresses only trip commands.
// - Permitted external trip block suppresses trip commands.
// - Only non-supervision elements feed the master.
// - Supervision-only elements keep states, no command.
// - Element alarm rises as soon as fault seen.
// - General alarm ORs forwarded element alarms.
// - Element trips if fault outlasts its delay.
// - General trip ORs forwarded element trips.
// - Trip command needs general trip, no blocking.
// - Phase alarms OR single-phase capable forwarded element alarms.
// - Phase trips OR single-phase capable forwarded element trips.
// - Each element has its own enable.
// - Stage permanent block suppresses its trip command.
// - Per-breaker map selects which commands trip it.
// - Stage temporary block needs permit and input.
module prot_trip_agg (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [3:0] fault_i,
  input wire logic [3:0][3:0] fault_phase_i,
  input wire logic ext_block_input_a_i,
  input wire logic ext_block_input_b_i,
  input wire logic ext_trip_block_input_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [3:0] elem_alarm_o,
  output logic [3:0] elem_trip_o,
  output logic gen_alarm_o,
  output logic gen_trip_o,
  output logic [3:0] phase_alarm_o,
  output logic [3:0] phase_trip_o,
  output logic [3:0] trip_command_o,
  output logic [1:0] breaker_trip_o,
  output logic prot_blocked_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] ctrl_q;
  logic [3:0] elem_en_q;
  logic [3:0] superv_q;
  logic [7:0] stage_blk_q;
  logic [3:0] phase_cap_q;
  logic [7:0] brk_map_q;
  logic [15:0] delay_q [prot_agg_pkg::NUM_ELEM];
  logic [15:0] cnt_q [prot_agg_pkg::NUM_ELEM];
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic prot_run;
  logic [3:0] elem_act;
  logic [3:0] fwd;
  logic [3:0] elem_alarm_d;
  logic [3:0] elem_trip_d;
  logic gen_alarm_d;
  logic gen_trip_d;
  logic [3:0] phase_alarm_d;
  logic [3:0] phase_trip_d;
  logic glob_tblk;
  logic [3:0] stage_tblk;
  logic [3:0] trip_command_d;
  logic [1:0] breaker_d;
  logic [3:0] irq_ev;
  logic [3:0] irq_clr;
  logic [3:0] irq_stat_d;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] wr_val;
  logic [31:0] wr_lane;
  logic [31:0] rd_val;
  logic rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Blocking inputs are pins, so they are synchronised before any use.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {ext_trip_block_input_i, ext_block_input_b_i,
                  ext_block_input_a_i};
      sync2_q <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prot_run = ctrl_q[prot_agg_pkg::CTRL_PROT_EN] &
    ~(ctrl_q[prot_agg_pkg::CTRL_EXT_BLK_PERMIT] &
      (sync2_q[0] | sync2_q[1]));
  assign elem_act = {4{prot_run}} & elem_en_q;
  assign fwd = ~superv_q;
  assign elem_alarm_d = elem_act & fault_i;
  assign gen_alarm_d = |(elem_alarm_d & fwd);
  assign gen_trip_d = |(elem_trip_d & fwd);
  assign glob_tblk = ctrl_q[prot_agg_pkg::CTRL_TRIP_PERM_BLK] |
    (ctrl_q[prot_agg_pkg::CTRL_EXT_TRIP_PERMIT] & sync2_q[2]);
  assign stage_tblk = stage_blk_q[3:0] |
    (stage_blk_q[7:4] & {4{sync2_q[2]}});
  assign trip_command_d = {4{gen_trip_d & ~glob_tblk}} &
    elem_trip_d & fwd & ~stage_tblk;

  // The trip only forms while the fault is still present at expiry.
  always_comb
  begin
    for (int e = 0; e < prot_agg_pkg::NUM_ELEM; e++)
      elem_trip_d[e] = elem_act[e] & fault_i[e] &
        (cnt_q[e] >= delay_q[e]);
  end

  always_comb
  begin
    phase_alarm_d = 4'h0;
    phase_trip_d = 4'h0;
    for (int e = 0; e < prot_agg_pkg::NUM_ELEM; e++)
    begin
      for (int p = 0; p < prot_agg_pkg::NUM_PHASE; p++)
      begin
        phase_alarm_d[p] = phase_alarm_d[p] | (elem_alarm_d[e] & fwd[e] &
          phase_cap_q[e] & fault_phase_i[e][p]);
        phase_trip_d[p] = phase_trip_d[p] | (elem_trip_d[e] & fwd[e] &
          phase_cap_q[e] & fault_phase_i[e][p]);
      end
    end
  end

  always_comb
  begin
    for (int b = 0; b < prot_agg_pkg::NUM_BRK; b++)
      breaker_d[b] = |(trip_command_d & brk_map_q[b*4 +: 4]);
  end

  // Reset delay is instantaneous: the timer restarts once the fault drops.
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int e = 0; e < prot_agg_pkg::NUM_ELEM; e++)
        cnt_q[e] <= 16'h0000;
    end
    else
    begin
      for (int e = 0; e < prot_agg_pkg::NUM_ELEM; e++)
      begin
        if (!(elem_act[e] && fault_i[e]))
          cnt_q[e] <= 16'h0000;
        else if (cnt_q[e] < delay_q[e])
          cnt_q[e] <= cnt_q[e] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      elem_alarm_o <= 4'h0;
      elem_trip_o <= 4'h0;
      gen_alarm_o <= 1'b0;
      gen_trip_o <= 1'b0;
      phase_alarm_o <= 4'h0;
      phase_trip_o <= 4'h0;
      trip_command_o <= 4'h0;
      breaker_trip_o <= 2'h0;
      prot_blocked_o <= 1'b0;
    end
    else
    begin
      elem_alarm_o <= elem_alarm_d;
      elem_trip_o <= elem_trip_d;
      gen_alarm_o <= gen_alarm_d;
      gen_trip_o <= gen_trip_d;
      phase_alarm_o <= phase_alarm_d;
      phase_trip_o <= phase_trip_d;
      trip_command_o <= trip_command_d;
      breaker_trip_o <= breaker_d;
      prot_blocked_o <= ~prot_run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events are rising edges; a set in the clearing cycle wins.
  assign irq_ev = {~prot_run & ~prot_blocked_o,
                   (|trip_command_d) & ~(|trip_command_o),
                   gen_trip_d & ~gen_trip_o,
                   gen_alarm_d & ~gen_alarm_o};
  assign irq_clr = (wr_fire && wr_ok &&
                    aw_addr_q[7:0] == prot_agg_pkg::IRQ_STAT_OFS) ?
                   wr_val[3:0] : 4'h0;
  assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_stat_q <= 4'h0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_o <= |(irq_stat_d & irq_mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One write and one read at a time; address and data in either order.
  assign wr_fire = aw_hold_q & w_hold_q & ~s_axi_bvalid_o;
  assign wr_ok = (aw_addr_q[31:8] == 24'h000000) &&
    (aw_addr_q[1:0] == 2'b00) && (aw_addr_q[7:0] <= prot_agg_pkg::IRQ_MASK_OFS)
    && (aw_addr_q[7:0] != prot_agg_pkg::STATUS_OFS);
  assign wr_lane = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  assign wr_val = w_data_q & wr_lane;

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= prot_agg_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? prot_agg_pkg::RESP_OKAY :
                                 prot_agg_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i)
      begin
        s_axi_bvalid_o <= 1'b0;
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= prot_agg_pkg::CTRL_RST;
      elem_en_q <= prot_agg_pkg::ELEM_EN_RST;
      superv_q <= prot_agg_pkg::SUPERV_RST;
      stage_blk_q <= prot_agg_pkg::STAGE_BLK_RST;
      phase_cap_q <= prot_agg_pkg::PHASE_CAP_RST;
      brk_map_q <= prot_agg_pkg::BRK_MAP_RST;
      irq_mask_q <= prot_agg_pkg::IRQ_MASK_RST;
      for (int e = 0; e < prot_agg_pkg::NUM_ELEM; e++)
        delay_q[e] <= prot_agg_pkg::DELAY_RST;
    end
    else if (wr_fire && wr_ok)
    begin
      unique case (aw_addr_q[7:0])
        prot_agg_pkg::CTRL_OFS:
          ctrl_q <= wr_val[3:0] | (ctrl_q & ~wr_lane[3:0]);
        prot_agg_pkg::ELEM_EN_OFS:
          elem_en_q <= wr_val[3:0] | (elem_en_q & ~wr_lane[3:0]);
        prot_agg_pkg::SUPERV_OFS:
          superv_q <= wr_val[3:0] | (superv_q & ~wr_lane[3:0]);
        prot_agg_pkg::STAGE_BLK_OFS:
          stage_blk_q <= wr_val[7:0] | (stage_blk_q & ~wr_lane[7:0]);
        prot_agg_pkg::PHASE_CAP_OFS:
          phase_cap_q <= wr_val[3:0] | (phase_cap_q & ~wr_lane[3:0]);
        prot_agg_pkg::BRK_MAP_OFS:
          brk_map_q <= wr_val[7:0] | (brk_map_q & ~wr_lane[7:0]);
        prot_agg_pkg::DELAY0_OFS:
          delay_q[0] <= wr_val[15:0] | (delay_q[0] & ~wr_lane[15:0]);
        prot_agg_pkg::DELAY1_OFS:
          delay_q[1] <= wr_val[15:0] | (delay_q[1] & ~wr_lane[15:0]);
        prot_agg_pkg::DELAY2_OFS:
          delay_q[2] <= wr_val[15:0] | (delay_q[2] & ~wr_lane[15:0]);
        prot_agg_pkg::DELAY3_OFS:
          delay_q[3] <= wr_val[15:0] | (delay_q[3] & ~wr_lane[15:0]);
        prot_agg_pkg::IRQ_MASK_OFS:
          irq_mask_q <= wr_val[3:0] | (irq_mask_q & ~wr_lane[3:0]);
        default:
          irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  always_comb
  begin
    rd_ok = (s_axi_araddr_i[31:8] == 24'h000000) &&
      (s_axi_araddr_i[1:0] == 2'b00);
    unique case (s_axi_araddr_i[7:0])
      prot_agg_pkg::CTRL_OFS: rd_val = {28'h0, ctrl_q};
      prot_agg_pkg::ELEM_EN_OFS: rd_val = {28'h0, elem_en_q};
      prot_agg_pkg::SUPERV_OFS: rd_val = {28'h0, superv_q};
      prot_agg_pkg::STAGE_BLK_OFS: rd_val = {24'h0, stage_blk_q};
      prot_agg_pkg::PHASE_CAP_OFS: rd_val = {28'h0, phase_cap_q};
      prot_agg_pkg::BRK_MAP_OFS: rd_val = {24'h0, brk_map_q};
      prot_agg_pkg::DELAY0_OFS: rd_val = {16'h0, delay_q[0]};
      prot_agg_pkg::DELAY1_OFS: rd_val = {16'h0, delay_q[1]};
      prot_agg_pkg::DELAY2_OFS: rd_val = {16'h0, delay_q[2]};
      prot_agg_pkg::DELAY3_OFS: rd_val = {16'h0, delay_q[3]};
      prot_agg_pkg::STATUS_OFS:
        rd_val = {7'h00, breaker_trip_o, prot_blocked_o, trip_command_o,
                  gen_trip_o, gen_alarm_o, phase_trip_o, phase_alarm_o,
                  elem_trip_o, elem_alarm_o};
      prot_agg_pkg::IRQ_STAT_OFS: rd_val = {28'h0, irq_stat_q};
      prot_agg_pkg::IRQ_MASK_OFS: rd_val = {28'h0, irq_mask_q};
      default:
      begin
        rd_val = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= prot_agg_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_ok ? rd_val : 32'h00000000;
      s_axi_rresp_o <= rd_ok ? prot_agg_pkg::RESP_OKAY :
                               prot_agg_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid_o && s_axi_rready_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks compare registered outputs with the settings of the cycle before.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_prot_off_quiet: assert property (
    !ctrl_q[0] |=> (elem_alarm_o == 4'h0) && (elem_trip_o == 4'h0)
      && (trip_command_o == 4'h0))
    else $error("Outputs active with protection disabled.");
  a_ext_block_all: assert property (
    ctrl_q[1] && (sync2_q[0] || sync2_q[1]) |=> !gen_alarm_o && !gen_trip_o)
    else $error("Protection active while externally blocked.");
  a_perm_trip_block: assert property (
    ctrl_q[2] |=> trip_command_o == 4'h0)
    else $error("Trip command despite permanent block.");
  a_ext_trip_block: assert property (
    ctrl_q[3] && sync2_q[2] |=> trip_command_o == 4'h0)
    else $error("Trip command despite external trip block.");
  a_gen_alarm_or: assert property (
    ##1 gen_alarm_o == |(elem_alarm_o & ~$past(superv_q)))
    else $error("General alarm differs from forwarded alarms.");
  a_gen_trip_or: assert property (
    ##1 gen_trip_o == |(elem_trip_o & ~$past(superv_q)))
    else $error("General trip differs from forwarded trips.");
  a_superv_no_cmd: assert property (
    ##1 (trip_command_o & $past(superv_q)) == 4'h0)
    else $error("Supervision element issued a trip command.");
  a_alarm_on_fault: assert property (
    fault_i[0] && elem_act[0] |=> elem_alarm_o[0])
    else $error("Element alarm missing on fault.");
  a_trip_needs_fault: assert property (
    elem_trip_o[1] |-> $past(fault_i[1]) &&
      ($past(cnt_q[1]) >= $past(delay_q[1])))
    else $error("Element trip without fault past its delay.");
  a_cmd_needs_trip: assert property (
    trip_command_o[2] |-> gen_trip_o && elem_trip_o[2])
    else $error("Trip command without general trip.");
  a_stage_block: assert property (
    stage_blk_q[3] |=> !trip_command_o[3])
    else $error("Stage trip command despite stage block.");
  a_breaker_map: assert property (
    ##1 breaker_trip_o[0] == |(trip_command_o & $past(brk_map_q[3:0])))
    else $error("Breaker trip differs from its command map.");

  c_general_trip: cover property (fault_i[0] ##1 gen_alarm_o ##[1:20]
    trip_command_o[0]);
  c_blocked: cover property (ctrl_q[1] && sync2_q[0] ##1 prot_blocked_o);
  c_superv_trip: cover property (superv_q[1] && elem_trip_o[1]);
  c_irq: cover property (irq_o);

endmodule : prot_trip_agg

// File: prot_fault_src.sv
// Model of the protection elements' fault detectors feeding the block.
// Assumes the bench sets the wanted fault and phase pattern on the clock.
`timescale 1ns/1ps
module prot_fault_src (
  input wire logic [3:0] fault_set_i,
  input wire logic [3:0][3:0] phase_set_i,
  output logic [3:0] fault_o,
  output logic [3:0][3:0] fault_phase_o
);
  // A quiet detector reports no phase, so stale phase bits cannot leak.
  always_comb
  begin
    fault_o = fault_set_i;
    for (int e = 0; e < 4; e++)
    begin
      fault_phase_o[e] = fault_set_i[e] ? phase_set_i[e] : 4'h0;
    end
  end
endmodule : prot_fault_src

// File: test_protection_trip_aggregation_blocking.sv
// Self-checking bench for the protection aggregation block.
// Assumes the package and the fault source model are compiled first.
`timescale 1ns/1ps
module test_protection_trip_aggregation_blocking;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] flt = 4'h0;
  logic [3:0][3:0] fph = '0;
  logic blk_a = 1'b0;
  logic blk_b = 1'b0;
  logic tblk = 1'b0;
  logic [31:0] aw_addr = 32'h0;
  logic [31:0] w_data = 32'h0;
  logic [31:0] ar_addr = 32'h0;
  logic aw_vld = 1'b0;
  logic w_vld = 1'b0;
  logic b_rdy = 1'b0;
  logic ar_vld = 1'b0;
  logic r_rdy = 1'b0;
  logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, ga, gt, blkd, irq;
  logic [1:0] b_resp, r_resp, brk;
  logic [31:0] r_data;
  logic [3:0] ea, et, pa, pt, tc, fault;
  logic [3:0][3:0] fault_ph;
  int err_total = 0;
  int n_tests = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  prot_fault_src src (.fault_set_i(flt), .phase_set_i(fph),
    .fault_o(fault), .fault_phase_o(fault_ph));

  prot_trip_agg dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .fault_i(fault), .fault_phase_i(fault_ph),
    .ext_block_input_a_i(blk_a), .ext_block_input_b_i(blk_b),
    .ext_trip_block_input_i(tblk),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_vld),
    .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_data),
    .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_vld), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld),
    .s_axi_bready_i(b_rdy), .s_axi_araddr_i(ar_addr),
    .s_axi_arvalid_i(ar_vld), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(r_data), .s_axi_rresp_o(r_resp),
    .s_axi_rvalid_o(r_vld), .s_axi_rready_i(r_rdy),
    .elem_alarm_o(ea), .elem_trip_o(et), .gen_alarm_o(ga),
    .gen_trip_o(gt), .phase_alarm_o(pa), .phase_trip_o(pt),
    .trip_command_o(tc), .breaker_trip_o(brk), .prot_blocked_o(blkd),
    .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    begin
      $display("mismatches %0d of %0d checks", err_total, n_tests);
      if (err_total == 0 && n_tests > 0)
      begin
        $display("ALL TESTS PASSED");
      end
      else
      begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests++;
      if (got !== exp)
      begin
        err_total++;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask : chk

  function automatic logic sel(input int k);
    case (k)
      0: sel = b_vld;
      1: sel = ar_rdy;
      default: sel = r_vld;
    endcase
  endfunction : sel

  // Every wait is bounded; a stuck handshake ends the run as a failure.
  task automatic wait_hi(input int k);
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge clk_sys_i);
        n++;
      end
      while (sel(k) !== 1'b1 && n < 60);
      if (sel(k) !== 1'b1)
      begin
        chk(32'(sel(k)), 32'h1);
        final_report();
      end
    end
  endtask : wait_hi

  task automatic step(input int k);
    begin
      repeat (k) @(posedge clk_sys_i);
      #1;
    end
  endtask : step

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    logic pa_w;
    logic pd_w;
    begin
      pa_w = 1'b1;
      pd_w = 1'b1;
      @(posedge clk_sys_i);
      aw_addr <= {24'h0, a};
      w_data <= d;
      aw_vld <= 1'b1;
      w_vld <= 1'b1;
      b_rdy <= 1'b1;
      for (int n = 0; (pa_w || pd_w) && n < 60; n++)
      begin
        @(posedge clk_sys_i);
        if (pa_w && aw_rdy === 1'b1)
        begin
          pa_w = 1'b0;
          aw_vld <= 1'b0;
        end
        if (pd_w && w_rdy === 1'b1)
        begin
          pd_w = 1'b0;
          w_vld <= 1'b0;
        end
      end
      if (pa_w || pd_w)
      begin
        chk(32'({pa_w, pd_w}), 32'h0);
        final_report();
      end
      wait_hi(0);
      b_rdy <= 1'b0;
      chk(32'(b_resp), 32'(r));
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] r);
    begin
      @(posedge clk_sys_i);
      ar_addr <= {24'h0, a};
      ar_vld <= 1'b1;
      r_rdy <= 1'b1;
      wait_hi(1);
      ar_vld <= 1'b0;
      wait_hi(2);
      r_rdy <= 1'b0;
      chk(r_data, d);
      chk(32'(r_resp), 32'(r));
    end
  endtask : axi_rd

  // Blocking pins pass a synchroniser, so results are judged after settling.
  task automatic look(input logic [3:0] a, input logic t,
                      input logic [3:0] c, input logic b);
    begin
      step(6);
      chk(32'(ea), 32'(a));
      chk(32'(gt), 32'(t));
      chk(32'(tc), 32'(c));
      chk(32'(blkd), 32'(b));
    end
  endtask : look

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    begin
      chk(32'({ga, gt, tc, brk, blkd, irq}), 32'h0);
      axi_rd(8'h00, 32'(prot_agg_pkg::CTRL_RST), 2'b00);
      axi_rd(8'h04, 32'(prot_agg_pkg::ELEM_EN_RST), 2'b00);
      axi_rd(8'h14, 32'(prot_agg_pkg::BRK_MAP_RST), 2'b00);
      axi_rd(8'h34, 32'h0, 2'b10);
      axi_wr(8'h28, 32'h0, 2'b10);
    end
  endtask : t_reset

  task automatic t_timing;
    begin
      axi_wr(8'h18, 32'h2, 2'b00);
      axi_wr(8'h14, 32'h21, 2'b00);
      @(posedge clk_sys_i);
      flt <= 4'h1;
      fph[0] <= 4'h1;
      step(1);
      chk(32'({ea, pa, ga}), 32'h023);
      chk(32'(et), 32'h0);
      step(1);
      chk(32'(gt), 32'h0);
      step(1);
      chk(32'({et, pt, gt}), 32'h023);
      chk(32'({tc, brk}), 32'h05);
      @(posedge clk_sys_i);
      flt <= 4'h0;
      step(2);
      chk(32'({ea, et}), 32'h0);
      @(posedge clk_sys_i);
      flt <= 4'h1;
      repeat (2) @(posedge clk_sys_i);
      flt <= 4'h0;
      step(1);
      chk(32'(et), 32'h0);
    end
  endtask : t_timing

  task automatic t_superv;
    begin
      axi_wr(8'h08, 32'h2, 2'b00);
      @(posedge clk_sys_i);
      flt <= 4'h2;
      fph[1] <= 4'h8;
      step(3);
      chk(32'({ea, et}), 32'h22);
      chk(32'({ga, gt, pa, pt}), 32'h0);
      chk(32'(tc), 32'h0);
      @(posedge clk_sys_i);
      flt <= 4'h0;
      axi_wr(8'h08, 32'h0, 2'b00);
      axi_wr(8'h10, 32'hd, 2'b00);
      @(posedge clk_sys_i);
      flt <= 4'h2;
      step(3);
      chk(32'({ga, gt, pa, pt}), 32'h300);
      @(posedge clk_sys_i);
      flt <= 4'h0;
      axi_wr(8'h10, 32'hf, 2'b00);
    end
  endtask : t_superv

  task automatic t_block;
    begin
      @(posedge clk_sys_i);
      flt <= 4'h1;
      look(4'h1, 1'b1, 4'h1, 1'b0);
      axi_wr(8'h00, 32'h0, 2'b00);
      look(4'h0, 1'b0, 4'h0, 1'b1);
      axi_wr(8'h00, 32'h3, 2'b00);
      @(posedge clk_sys_i);
      blk_a <= 1'b1;
      look(4'h0, 1'b0, 4'h0, 1'b1);
      @(posedge clk_sys_i);
      blk_a <= 1'b0;
      blk_b <= 1'b1;
      look(4'h0, 1'b0, 4'h0, 1'b1);
      axi_wr(8'h00, 32'h1, 2'b00);
      look(4'h1, 1'b1, 4'h1, 1'b0);
      @(posedge clk_sys_i);
      blk_b <= 1'b0;
      axi_wr(8'h00, 32'h5, 2'b00);
      look(4'h1, 1'b1, 4'h0, 1'b0);
      axi_wr(8'h00, 32'h9, 2'b00);
      @(posedge clk_sys_i);
      tblk <= 1'b1;
      look(4'h1, 1'b1, 4'h0, 1'b0);
      axi_wr(8'h00, 32'h1, 2'b00);
      look(4'h1, 1'b1, 4'h1, 1'b0);
      axi_wr(8'h0c, 32'h1, 2'b00);
      look(4'h1, 1'b1, 4'h0, 1'b0);
      axi_wr(8'h0c, 32'h10, 2'b00);
      look(4'h1, 1'b1, 4'h0, 1'b0);
      @(posedge clk_sys_i);
      tblk <= 1'b0;
      look(4'h1, 1'b1, 4'h1, 1'b0);
      axi_wr(8'h0c, 32'h0, 2'b00);
      axi_wr(8'h04, 32'he, 2'b00);
      look(4'h0, 1'b0, 4'h0, 1'b0);
      axi_wr(8'h04, 32'hf, 2'b00);
      @(posedge clk_sys_i);
      flt <= 4'h0;
    end
  endtask : t_block

  task automatic t_irq;
    begin
      step(4);
      axi_wr(8'h2c, 32'hf, 2'b00);
      axi_rd(8'h2c, 32'h0, 2'b00);
      @(posedge clk_sys_i);
      flt <= 4'h1;
      step(6);
      chk(32'(irq), 32'h0);
      axi_rd(8'h2c, 32'h7, 2'b00);
      axi_wr(8'h30, 32'h2, 2'b00);
      step(2);
      chk(32'(irq), 32'h1);
      axi_wr(8'h2c, 32'h2, 2'b00);
      step(2);
      chk(32'(irq), 32'h0);
      axi_rd(8'h2c, 32'h5, 2'b00);
    end
  endtask : t_irq

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    step(1);
    t_reset();
    t_timing();
    t_superv();
    t_block();
    t_irq();
    final_report();
  end
endmodule : test_protection_trip_aggregation_blocking
